// file: logic/evict_pkg.sv
package evict_pkg;

   // ==========================================================
   // Page types and result codes
   localparam logic [7:0] REGULAR_PAGE_TYPE        = 8'h03;
   localparam logic [7:0] THREAD_CONTROL_PAGE_TYPE = 8'h01;
   localparam logic [7:0] TRIMMED_PAGE_TYPE        = 8'h04;
   localparam logic [7:0] CONTROL_PAGE_TYPE        = 8'h00;
   localparam logic [7:0] VERSION_PAGE_TYPE        = 8'h02;

   localparam logic [31:0] ERR_NONE                = 32'h0000_0000;
   localparam logic [31:0] ERR_PAGE_UNBLOCKED      = 32'h0000_0001;
   localparam logic [31:0] ERR_TRACKING_INCOMPLETE = 32'h0000_0002;
   localparam logic [31:0] ERR_CHILDREN_RESIDENT   = 32'h0000_0003;
   localparam logic [31:0] ERR_SLOT_IN_USE         = 32'h0000_0004;

   // ==========================================================
   // Alignment masks and sizes
   localparam logic [63:0] ALIGN_32_MASK  = 64'h0000_0000_0000_001F;
   localparam logic [63:0] ALIGN_4K_MASK  = 64'h0000_0000_0000_0FFF;
   localparam logic [63:0] ALIGN_8_MASK   = 64'h0000_0000_0000_0007;
   localparam logic [63:0] ALIGN_128_MASK = 64'h0000_0000_0000_007F;
   localparam logic [1:0]  PRIV_TOP       = 2'h0;
   localparam int          VER_SHIFT      = 32;
   localparam logic [12:0] PAGE_BYTES     = 13'h1000;
   localparam logic [7:0]  HEADER_BYTES   = 8'h80;

   // ==========================================================
   // Fault kinds and sequencer states
   typedef enum logic [1:0]
   {
      FAULT_NONE = 2'b00,
      FAULT_GP   = 2'b01,
      FAULT_PF   = 2'b10
   } fault_t;

   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'b000,
      ST_CHECK   = 3'b001,
      ST_CRYPT   = 3'b010,
      ST_WAIT    = 3'b011,
      ST_SLOT    = 3'b100,
      ST_DONE    = 3'b101
   } state_t;

endpackage : evict_pkg

// file: logic/evict_check.sv
module evict_check
(
   input  wire logic [1:0]  i_priv,
   input  wire logic [63:0] i_desc_ptr,
   input  wire logic [63:0] i_page_ptr,
   input  wire logic [63:0] i_slot_ptr,
   input  wire logic [63:0] i_meta_ptr,
   input  wire logic [63:0] i_buf_ptr,
   input  wire logic        i_desc_fields_nz,
   input  wire logic        i_page_in_cache,
   input  wire logic        i_slot_in_cache,
   input  wire logic        i_page_busy,
   input  wire logic        i_va_changing,
   input  wire logic        i_page_valid,
   input  wire logic        i_slot_page_valid,
   input  wire logic [7:0]  i_slot_page_type,
   input  wire logic        i_owned,
   input  wire logic        i_block_ok,
   output logic [1:0]       o_fault,
   output logic             o_fault_on_slot
);
   logic gp;
   logic pf_page;
   logic pf_slot;

   // ==========================================================
   // Fault decode in documented order
   always_comb
   begin
      gp      = 1'b0;
      pf_page = 1'b0;
      pf_slot = 1'b0;
      if (i_priv != evict_pkg::PRIV_TOP)
         gp = 1'b1;
      else if (((i_desc_ptr & evict_pkg::ALIGN_32_MASK) != 64'h0)
               || ((i_page_ptr & evict_pkg::ALIGN_4K_MASK) != 64'h0))
         gp = 1'b1;
      else if (!i_page_in_cache)
         pf_page = 1'b1;
      else if ((i_slot_ptr & evict_pkg::ALIGN_8_MASK) != 64'h0)
         gp = 1'b1;
      else if (!i_slot_in_cache)
         pf_slot = 1'b1;
      else if ((i_page_ptr & ~evict_pkg::ALIGN_4K_MASK)
               == (i_slot_ptr & ~evict_pkg::ALIGN_4K_MASK))
         gp = 1'b1;
      else if (i_desc_fields_nz)
         gp = 1'b1;
      else if (((i_meta_ptr & evict_pkg::ALIGN_128_MASK) != 64'h0)
               || ((i_buf_ptr & evict_pkg::ALIGN_4K_MASK) != 64'h0))
         gp = 1'b1;
      else if (i_page_busy)
         gp = 1'b1;
      else if (i_va_changing)
         gp = 1'b1;
      else if (!i_page_valid)
         pf_page = 1'b1;
      else if (!i_slot_page_valid
               || (i_slot_page_type != evict_pkg::VERSION_PAGE_TYPE))
         pf_slot = 1'b1;
      else if (i_owned && !i_block_ok)
         gp = 1'b1;
      o_fault         = gp ? evict_pkg::FAULT_GP
                      : ((pf_page || pf_slot) ? evict_pkg::FAULT_PF : evict_pkg::FAULT_NONE);
      o_fault_on_slot = pf_slot;
   end
endmodule : evict_check

// file: logic/evict_header.sv
module evict_header
(
   input  wire logic [63:0]   i_lin_addr,
   input  wire logic [7:0]    i_page_type,
   input  wire logic [2:0]    i_rights,
   input  wire logic          i_pending,
   input  wire logic          i_modified,
   input  wire logic          i_restrict,
   input  wire logic [63:0]   i_hdr_eid,
   output logic      [1023:0] o_header
);
   // ==========================================================
   // Header: zero then fill
   always_comb
   begin
      o_header          = '0;
      o_header[63:0]    = i_hdr_eid;
      o_header[127:64]  = i_lin_addr;
      o_header[135:128] = i_page_type;
      o_header[138:136] = i_rights;
      o_header[139]     = i_pending;
      o_header[140]     = i_modified;
      o_header[141]     = i_restrict;
   end
endmodule : evict_header

// file: logic/page_evict_leaf.sv
module page_evict_leaf
(
   input  wire logic          I_REF_CLK,
   input  wire logic          I_NRST,
   input  wire logic          i_START,
   input  wire logic [1:0]    i_PRIV,
   input  wire logic [63:0]   i_DESC_PTR,
   input  wire logic [63:0]   i_PAGE_PTR,
   input  wire logic [63:0]   i_SLOT_PTR,
   input  wire logic [63:0]   i_META_PTR,
   input  wire logic [63:0]   i_BUF_PTR,
   input  wire logic          i_DESC_FIELDS_NZ,
   input  wire logic          i_PAGE_IN_CACHE,
   input  wire logic          i_SLOT_IN_CACHE,
   input  wire logic          i_PAGE_BUSY,
   input  wire logic          i_VA_CHANGING,
   input  wire logic          i_PAGE_VALID,
   input  wire logic [7:0]    i_PAGE_TYPE,
   input  wire logic [2:0]    i_RIGHTS,
   input  wire logic          i_PENDING,
   input  wire logic          i_MODIFIED,
   input  wire logic          i_RESTRICT,
   input  wire logic          i_BLOCKED,
   input  wire logic [63:0]   i_LIN_ADDR,
   input  wire logic          i_SLOT_PAGE_VALID,
   input  wire logic [7:0]    i_SLOT_PAGE_TYPE,
   input  wire logic          i_BLOCK_OK,
   input  wire logic          i_TRACK_OK,
   input  wire logic [63:0]   i_OWNER_EID,
   input  wire logic [63:0]   i_OWN_EID,
   input  wire logic          i_CHILDREN,
   input  wire logic [63:0]   i_VERSION,
   input  wire logic [63:0]   i_SLOT_VALUE,
   input  wire logic          i_CRYPT_DONE,
   input  wire logic [127:0]  i_CRYPT_MAC,
   output logic               o_BUSY,
   output logic               o_DONE,
   output logic [1:0]         o_FAULT,
   output logic               o_FAULT_ON_SLOT,
   output logic [31:0]        o_RESULT,
   output logic               o_ZERO_FLAG,
   output logic               o_CARRY_FLAG,
   output logic               o_CRYPT_START,
   output logic [1023:0]      o_CRYPT_HEADER,
   output logic [127:0]       o_CRYPT_COUNTER,
   output logic [12:0]        o_CRYPT_LEN,
   output logic [7:0]         o_CRYPT_HDR_LEN,
   output logic               o_META_WE,
   output logic [7:0]         o_META_TYPE,
   output logic [2:0]         o_META_RIGHTS,
   output logic               o_META_PENDING,
   output logic               o_META_MODIFIED,
   output logic               o_META_RESTRICT,
   output logic [63:0]        o_META_EID,
   output logic [127:0]       o_META_MAC,
   output logic               o_DESC_WE,
   output logic [63:0]        o_DESC_LIN_ADDR,
   output logic               o_SLOT_WE,
   output logic [63:0]        o_SLOT_DATA,
   output logic               o_INVALIDATE
);
   typedef struct packed
   {
      evict_pkg::state_t st;
      logic [1:0]        fault;
      logic              fault_on_slot;
      logic [31:0]       result;
      logic              zf;
      logic              cf;
      logic              done;
      logic              crypt_start;
      logic [1023:0]     header;
      logic [127:0]      counter;
      logic              meta_we;
      logic [63:0]       meta_eid;
      logic [127:0]      mac;
      logic              desc_we;
      logic              slot_we;
      logic [63:0]       slot_data;
      logic              invalidate;
   } regs_t;

   regs_t                r;
   regs_t                next_r;
   logic  [1:0]          chk_fault;
   logic                 chk_on_slot;
   logic                 owned;
   logic  [63:0]         hdr_eid;
   logic  [63:0]         meta_eid;
   logic  [1023:0]       header;

   // ==========================================================
   // Page classification and identifiers
   always_comb
   begin
      owned = (i_PAGE_TYPE == evict_pkg::REGULAR_PAGE_TYPE)
           || (i_PAGE_TYPE == evict_pkg::THREAD_CONTROL_PAGE_TYPE)
           || (i_PAGE_TYPE == evict_pkg::TRIMMED_PAGE_TYPE);
      hdr_eid  = 64'h0;
      meta_eid = 64'h0;
      if (owned)
      begin
         hdr_eid  = i_OWNER_EID;
         meta_eid = i_OWNER_EID;
      end
      else if (i_PAGE_TYPE == evict_pkg::CONTROL_PAGE_TYPE)
      begin
         hdr_eid  = 64'h0;
         meta_eid = i_OWN_EID;
      end
   end

   evict_check u_check
   (
      .i_priv            (i_PRIV),
      .i_desc_ptr        (i_DESC_PTR),
      .i_page_ptr        (i_PAGE_PTR),
      .i_slot_ptr        (i_SLOT_PTR),
      .i_meta_ptr        (i_META_PTR),
      .i_buf_ptr         (i_BUF_PTR),
      .i_desc_fields_nz  (i_DESC_FIELDS_NZ),
      .i_page_in_cache   (i_PAGE_IN_CACHE),
      .i_slot_in_cache   (i_SLOT_IN_CACHE),
      .i_page_busy       (i_PAGE_BUSY),
      .i_va_changing     (i_VA_CHANGING),
      .i_page_valid      (i_PAGE_VALID),
      .i_slot_page_valid (i_SLOT_PAGE_VALID),
      .i_slot_page_type  (i_SLOT_PAGE_TYPE),
      .i_owned           (owned),
      .i_block_ok        (i_BLOCK_OK),
      .o_fault           (chk_fault),
      .o_fault_on_slot   (chk_on_slot)
   );

   evict_header u_header
   (
      .i_lin_addr  (i_LIN_ADDR),
      .i_page_type (i_PAGE_TYPE),
      .i_rights    (i_RIGHTS),
      .i_pending   (i_PENDING),
      .i_modified  (i_MODIFIED),
      .i_restrict  (i_RESTRICT),
      .i_hdr_eid   (hdr_eid),
      .o_header    (header)
   );

   // ==========================================================
   // Sequencer
   always_comb
   begin
      next_r             = r;
      next_r.done        = 1'b0;
      next_r.crypt_start = 1'b0;
      next_r.meta_we     = 1'b0;
      next_r.desc_we     = 1'b0;
      next_r.slot_we     = 1'b0;
      next_r.invalidate  = 1'b0;
      unique case (r.st)
         evict_pkg::ST_IDLE:
         begin
            if (i_START)
               next_r.st = evict_pkg::ST_CHECK;
         end
         evict_pkg::ST_CHECK:
         begin
            next_r.fault         = chk_fault;
            next_r.fault_on_slot = chk_on_slot;
            next_r.result        = evict_pkg::ERR_NONE;
            next_r.zf            = 1'b0;
            next_r.cf            = 1'b0;
            next_r.st            = evict_pkg::ST_DONE;
            if (chk_fault != evict_pkg::FAULT_NONE)
               next_r.st = evict_pkg::ST_DONE;
            else if (owned && !i_BLOCKED)
            begin
               next_r.result = evict_pkg::ERR_PAGE_UNBLOCKED;
               next_r.zf     = 1'b1;
            end
            else if (owned && !i_TRACK_OK)
            begin
               next_r.result = evict_pkg::ERR_TRACKING_INCOMPLETE;
               next_r.zf     = 1'b1;
            end
            else if ((i_PAGE_TYPE == evict_pkg::CONTROL_PAGE_TYPE) && i_CHILDREN)
            begin
               next_r.result = evict_pkg::ERR_CHILDREN_RESIDENT;
               next_r.zf     = 1'b1;
            end
            else
            begin
               next_r.header      = header;
               next_r.meta_eid    = meta_eid;
               next_r.counter     = {i_VERSION, 64'h0} >> evict_pkg::VER_SHIFT;
               next_r.crypt_start = 1'b1;
               next_r.slot_data   = i_VERSION;
               next_r.st          = evict_pkg::ST_WAIT;
            end
            if (next_r.st == evict_pkg::ST_DONE)
               next_r.done = 1'b1;
            if (next_r.st == evict_pkg::ST_DONE)
               next_r.st = evict_pkg::ST_IDLE;
         end
         evict_pkg::ST_WAIT:
         begin
            if (i_CRYPT_DONE)
            begin
               next_r.mac     = i_CRYPT_MAC;
               next_r.meta_we = 1'b1;
               next_r.desc_we = 1'b1;
               next_r.st      = evict_pkg::ST_SLOT;
            end
         end
         evict_pkg::ST_SLOT:
         begin
            if (i_SLOT_VALUE != 64'h0)
            begin
               next_r.result = evict_pkg::ERR_SLOT_IN_USE;
               next_r.cf     = 1'b1;
            end
            next_r.slot_we = 1'b1;
            next_r.st      = evict_pkg::ST_DONE;
         end
         evict_pkg::ST_DONE:
         begin
            next_r.invalidate = 1'b1;
            next_r.done       = 1'b1;
            next_r.st         = evict_pkg::ST_IDLE;
         end
         default:
            next_r.st = evict_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         r    <= '0;
         r.st <= evict_pkg::ST_IDLE;
      end
      else
         r <= next_r;
   end

   // ==========================================================
   // Outputs
   assign o_BUSY          = (r.st != evict_pkg::ST_IDLE);
   assign o_DONE          = r.done;
   assign o_FAULT         = r.fault;
   assign o_FAULT_ON_SLOT = r.fault_on_slot;
   assign o_RESULT        = r.result;
   assign o_ZERO_FLAG     = r.zf;
   assign o_CARRY_FLAG    = r.cf;
   assign o_CRYPT_START   = r.crypt_start;
   assign o_CRYPT_HEADER  = r.header;
   assign o_CRYPT_COUNTER = r.counter;
   assign o_CRYPT_LEN     = evict_pkg::PAGE_BYTES;
   assign o_CRYPT_HDR_LEN = evict_pkg::HEADER_BYTES;
   assign o_META_WE       = r.meta_we;
   assign o_META_TYPE     = r.header[135:128];
   assign o_META_RIGHTS   = r.header[138:136];
   assign o_META_PENDING  = r.header[139];
   assign o_META_MODIFIED = r.header[140];
   assign o_META_RESTRICT = r.header[141];
   assign o_META_EID      = r.meta_eid;
   assign o_META_MAC      = r.mac;
   assign o_DESC_WE       = r.desc_we;
   assign o_DESC_LIN_ADDR = r.header[127:64];
   assign o_SLOT_WE       = r.slot_we;
   assign o_SLOT_DATA     = r.slot_data;
   assign o_INVALIDATE    = r.invalidate;
endmodule : page_evict_leaf

// file: testbench/page_evict_leaf_assertions.sv
module page_evict_leaf_sva
(
   input  logic          I_REF_CLK,
   input  logic          I_NRST,
   input  logic          i_START,
   input  logic [1:0]    i_PRIV,
   input  logic [7:0]    i_PAGE_TYPE,
   input  logic [63:0]   i_LIN_ADDR,
   input  logic [63:0]   i_VERSION,
   input  logic [63:0]   i_SLOT_VALUE,
   input  logic          i_CRYPT_DONE,
   input  logic          o_BUSY,
   input  logic          o_DONE,
   input  logic [1:0]    o_FAULT,
   input  logic [31:0]   o_RESULT,
   input  logic          o_ZERO_FLAG,
   input  logic          o_CARRY_FLAG,
   input  logic          o_CRYPT_START,
   input  logic [1023:0] o_CRYPT_HEADER,
   input  logic [127:0]  o_CRYPT_COUNTER,
   input  logic [12:0]   o_CRYPT_LEN,
   input  logic [7:0]    o_CRYPT_HDR_LEN,
   input  logic          o_META_WE,
   input  logic [63:0]   o_META_EID,
   input  logic          o_DESC_WE,
   input  logic [63:0]   o_DESC_LIN_ADDR,
   input  logic          o_SLOT_WE,
   input  logic [63:0]   o_SLOT_DATA,
   input  logic          o_INVALIDATE
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_NRST);

   // ==========================================================
   // Sequencing
   AST_DONE_BOUND: assert property (i_START && !o_BUSY |-> ##[2:60] o_DONE)
      else $error("operation did not complete in time");
   AST_FAULT_TIMING: assert property (o_DONE && o_FAULT != 2'h0 |-> $past(i_START, 2))
      else $error("fault completion not two cycles after start");
   AST_NO_WRITE_ON_FAULT: assert property (o_DONE && o_FAULT != 2'h0 |->
      !(o_META_WE || o_DESC_WE || o_SLOT_WE || o_INVALIDATE || $past(o_CRYPT_START)))
      else $error("state changed on a faulting eviction");
   AST_PRIV_GP: assert property (o_DONE && i_PRIV != 2'h0 |-> o_FAULT == 2'h1)
      else $error("nonzero privilege not refused");
   AST_META_AFTER_CRYPT: assert property (i_CRYPT_DONE && o_BUSY |=> o_META_WE && o_DESC_WE
      && o_DESC_LIN_ADDR == i_LIN_ADDR)
      else $error("metadata write missing after crypt done");
   AST_SLOT_AFTER_META: assert property (o_META_WE |=> o_SLOT_WE && o_SLOT_DATA == i_VERSION)
      else $error("slot write missing or wrong after metadata");
   AST_INVAL_AFTER_SLOT: assert property (o_SLOT_WE |=> o_INVALIDATE && o_DONE)
      else $error("invalidate missing after slot write");
   AST_COUNTER: assert property (o_CRYPT_START |-> o_CRYPT_COUNTER == {32'h0, i_VERSION, 32'h0}
      && o_CRYPT_LEN == 13'h1000 && o_CRYPT_HDR_LEN == 8'h80)
      else $error("crypt counter or lengths wrong");
   AST_HEADER: assert property (o_CRYPT_START |-> o_CRYPT_HEADER[135:128] == i_PAGE_TYPE
      && o_CRYPT_HEADER[127:64] == i_LIN_ADDR && o_CRYPT_HEADER[1023:142] == '0)
      else $error("header fields wrong");
   AST_VA_EID: assert property (o_META_WE && i_PAGE_TYPE == evict_pkg::VERSION_PAGE_TYPE
      |-> o_META_EID == 64'h0)
      else $error("version page identifier not zero");
   AST_CARRY: assert property (o_DONE && o_INVALIDATE |->
      o_CARRY_FLAG == (i_SLOT_VALUE != 64'h0) && !o_ZERO_FLAG)
      else $error("carry flag does not follow slot content");
   AST_EARLY_EXIT: assert property (o_DONE && !o_INVALIDATE && o_FAULT == 2'h0 |->
      o_ZERO_FLAG && !o_CARRY_FLAG && o_RESULT != 32'h0)
      else $error("early exit flags wrong");

   // ==========================================================
   // Scenario coverage
   COV_PF: cover property (o_DONE && o_FAULT == 2'h2);
   COV_OCCUPIED: cover property (o_DONE && o_CARRY_FLAG);
   COV_CHILDREN: cover property (o_DONE && o_RESULT == evict_pkg::ERR_CHILDREN_RESIDENT);
endmodule : page_evict_leaf_sva

bind page_evict_leaf page_evict_leaf_sva u_sva (.*);

// file: testbench/crypto_engine_model.sv
module crypto_engine_model
#(
   parameter logic [127:0] MAC = 128'h0
)
(
   input  logic         i_clk,
   input  logic         i_nrst,
   input  logic [3:0]   i_delay,
   input  logic         i_start,
   output logic         o_done,
   output logic [127:0] o_mac
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cnt;
   logic       run;

   // Variable latency; tag bus toggles outside the done pulse
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt    <= 4'h0;
         run    <= 1'h0;
         o_done <= 1'h0;
         o_mac  <= 128'h0;
      end
      else
      begin
         o_done <= 1'h0;
         o_mac  <= ~o_mac;
         if (i_start)
         begin
            run <= 1'h1;
            cnt <= i_delay;
         end
         else if (run && cnt == 4'h0)
         begin
            run    <= 1'h0;
            o_done <= 1'h1;
            o_mac  <= MAC;
         end
         else if (run)
            cnt <= cnt - 4'h1;
      end
   end
endmodule : crypto_engine_model

// file: testbench/tb_page_evict_leaf.sv
module tb_page_evict_leaf;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [127:0] MAC = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [2:0] FEXP [0:15] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h6, 3'h1, 3'h1,
                                         3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h6, 3'h6, 3'h1};
   localparam logic [7:0] TYP [0:4] = '{evict_pkg::REGULAR_PAGE_TYPE,
      evict_pkg::THREAD_CONTROL_PAGE_TYPE, evict_pkg::TRIMMED_PAGE_TYPE,
      evict_pkg::CONTROL_PAGE_TYPE, evict_pkg::VERSION_PAGE_TYPE};
   localparam logic [31:0] EXIT_CODE [0:2] = '{evict_pkg::ERR_PAGE_UNBLOCKED,
      evict_pkg::ERR_TRACKING_INCOMPLETE, evict_pkg::ERR_CHILDREN_RESIDENT};
   logic I_REF_CLK, I_NRST, i_START, i_DESC_FIELDS_NZ, i_PAGE_IN_CACHE, i_SLOT_IN_CACHE;
   logic i_PAGE_BUSY, i_VA_CHANGING, i_PAGE_VALID, i_PENDING, i_MODIFIED, i_RESTRICT, i_BLOCKED;
   logic i_SLOT_PAGE_VALID, i_BLOCK_OK, i_TRACK_OK, i_CHILDREN, i_CRYPT_DONE;
   logic o_BUSY, o_DONE, o_FAULT_ON_SLOT, o_ZERO_FLAG, o_CARRY_FLAG, o_CRYPT_START, o_META_WE;
   logic o_META_PENDING, o_META_MODIFIED, o_META_RESTRICT, o_DESC_WE, o_SLOT_WE, o_INVALIDATE;
   logic [1:0]    i_PRIV, o_FAULT;
   logic [2:0]    i_RIGHTS, o_META_RIGHTS;
   logic [3:0]    delay;
   logic [7:0]    i_PAGE_TYPE, i_SLOT_PAGE_TYPE, o_META_TYPE, o_CRYPT_HDR_LEN;
   logic [12:0]   o_CRYPT_LEN;
   logic [31:0]   o_RESULT;
   logic [63:0]   i_DESC_PTR, i_PAGE_PTR, i_SLOT_PTR, i_META_PTR, i_BUF_PTR, i_LIN_ADDR;
   logic [63:0]   i_OWNER_EID, i_OWN_EID, i_VERSION, i_SLOT_VALUE, o_META_EID;
   logic [63:0]   o_DESC_LIN_ADDR, o_SLOT_DATA, cap_lin, cap_slot;
   logic [77:0]   cap_meta;
   logic [127:0]  i_CRYPT_MAC, o_CRYPT_COUNTER, o_META_MAC, cap_ctr, cap_mac;
   logic [1023:0] o_CRYPT_HEADER, cap_hdr, exp_hdr;
   int            bad_count, n_compared, n_w;

   page_evict_leaf u_dut (.*);
   crypto_engine_model #(.MAC(MAC)) u_crypt (.i_clk(I_REF_CLK), .i_nrst(I_NRST),
      .i_delay(delay), .i_start(o_CRYPT_START), .o_done(i_CRYPT_DONE), .o_mac(i_CRYPT_MAC));

   initial
   begin
      I_REF_CLK = 1'h0;
      forever #20 I_REF_CLK = ~I_REF_CLK;
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string name, input logic [1023:0] exp, input logic [1023:0] got);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   task automatic set_good();
      i_PRIV <= 2'h0;
      i_DESC_PTR <= 64'h0000_0000_0001_0020;
      i_PAGE_PTR <= 64'h0000_0000_0002_0000;
      i_SLOT_PTR <= 64'h0000_0000_0003_0008;
      i_META_PTR <= 64'h0000_0000_0004_0080;
      i_BUF_PTR <= 64'h0000_0000_0005_0000;
      {i_DESC_FIELDS_NZ, i_PAGE_BUSY, i_VA_CHANGING, i_MODIFIED, i_CHILDREN} <= 5'h00;
      {i_PAGE_IN_CACHE, i_SLOT_IN_CACHE, i_PAGE_VALID, i_SLOT_PAGE_VALID} <= 4'hF;
      {i_PENDING, i_RESTRICT, i_BLOCKED, i_BLOCK_OK, i_TRACK_OK} <= 5'h1F;
      i_RIGHTS <= 3'h5;
      i_SLOT_PAGE_TYPE <= evict_pkg::VERSION_PAGE_TYPE;
      i_LIN_ADDR <= 64'h0000_7F00_1234_5000;
      i_OWNER_EID <= 64'h0000_0000_0000_0A11;
      i_OWN_EID <= 64'h0000_0000_0000_0B22;
      i_VERSION <= 64'h0000_0000_1357_9BDF;
   endtask : set_good

   task automatic op(input int k, input logic [7:0] typ, input logic [63:0] sv);
      int i;
      n_w = 0;
      {cap_hdr, cap_ctr, cap_meta, cap_mac, cap_lin, cap_slot} = '0;
      @(posedge I_REF_CLK);
      set_good();
      i_PAGE_TYPE <= typ;
      i_SLOT_VALUE <= sv;
      case (k)
         0: i_PRIV <= 2'h1;
         1: i_DESC_PTR <= 64'h0000_0000_0001_0030;
         2: i_PAGE_PTR <= 64'h0000_0000_0002_0040;
         3: i_PAGE_IN_CACHE <= 1'h0;
         4: i_SLOT_PTR <= 64'h0000_0000_0003_000C;
         5: i_SLOT_IN_CACHE <= 1'h0;
         6: i_SLOT_PTR <= 64'h0000_0000_0002_0008;
         7: i_DESC_FIELDS_NZ <= 1'h1;
         8: i_META_PTR <= 64'h0000_0000_0004_00C0;
         9: i_BUF_PTR <= 64'h0000_0000_0005_0800;
         10: i_PAGE_BUSY <= 1'h1;
         11: i_VA_CHANGING <= 1'h1;
         12: i_PAGE_VALID <= 1'h0;
         13: i_SLOT_PAGE_VALID <= 1'h0;
         14: i_SLOT_PAGE_TYPE <= evict_pkg::REGULAR_PAGE_TYPE;
         15: i_BLOCK_OK <= 1'h0;
         16: i_BLOCKED <= 1'h0;
         17: i_TRACK_OK <= 1'h0;
         18: {i_PAGE_TYPE, i_CHILDREN} <= {evict_pkg::CONTROL_PAGE_TYPE, 1'h1};
         default: ;
      endcase
      i_START <= 1'h1;
      @(posedge I_REF_CLK);
      i_START <= 1'h0;
      for (i = 0; i < 100; i++)
      begin
         @(negedge I_REF_CLK);
         n_w += int'(o_META_WE) + int'(o_DESC_WE) + int'(o_SLOT_WE);
         n_w += int'(o_INVALIDATE) + int'(o_CRYPT_START);
         if (o_CRYPT_START)
            {cap_hdr, cap_ctr} = {o_CRYPT_HEADER, o_CRYPT_COUNTER};
         if (o_META_WE)
            cap_meta = {o_META_TYPE, o_META_RIGHTS, o_META_PENDING, o_META_MODIFIED,
                        o_META_RESTRICT, o_META_EID};
         if (o_META_WE)
            cap_mac = o_META_MAC;
         if (o_DESC_WE)
            cap_lin = o_DESC_LIN_ADDR;
         if (o_SLOT_WE)
            cap_slot = o_SLOT_DATA;
         if (o_DONE === 1'h1)
            break;
      end
      if (i == 100)
      begin
         bad_count++;
         $display("[FAIL] done expected 1 seen 0");
         print_verdict();
      end
   endtask : op

   task automatic chk_ok(input logic [63:0] he, input logic [63:0] me, input logic cf);
      exp_hdr = '0;
      exp_hdr[141:0] = {i_RESTRICT, i_MODIFIED, i_PENDING, i_RIGHTS, i_PAGE_TYPE, i_LIN_ADDR, he};
      chk("header", exp_hdr, cap_hdr);
      chk("counter", {32'h0, i_VERSION, 32'h0}, cap_ctr);
      chk("meta", {i_PAGE_TYPE, i_RIGHTS, i_PENDING, i_MODIFIED, i_RESTRICT, me}, cap_meta);
      chk("meta_mac", MAC, cap_mac);
      chk("desc_lin", i_LIN_ADDR, cap_lin);
      chk("slot_data", i_VERSION, cap_slot);
      chk("writes", 5, n_w);
      chk("busy", 1'h0, o_BUSY);
      chk("result", cf ? evict_pkg::ERR_SLOT_IN_USE : evict_pkg::ERR_NONE, o_RESULT);
      chk("flags", {1'h0, cf}, {o_ZERO_FLAG, o_CARRY_FLAG});
      chk("fault", evict_pkg::FAULT_NONE, o_FAULT);
   endtask : chk_ok

   // ==========================================================
   // Main sequence
   initial
   begin
      I_NRST = 1'h0;
      i_START = 1'h0;
      i_PAGE_TYPE = evict_pkg::REGULAR_PAGE_TYPE;
      i_SLOT_VALUE = 64'h0;
      delay = 4'h2;
      set_good();
      repeat (6) @(posedge I_REF_CLK);
      I_NRST <= 1'h1;
      for (int k = 0; k < 16; k++)
      begin
         op(k, evict_pkg::REGULAR_PAGE_TYPE, 64'h0);
         chk("fault", FEXP[k][1:0], o_FAULT);
         if (FEXP[k][1])
            chk("fault_on_slot", FEXP[k][2], o_FAULT_ON_SLOT);
         chk("writes", 0, n_w);
      end
      for (int k = 16; k < 19; k++)
      begin
         op(k, evict_pkg::REGULAR_PAGE_TYPE, 64'h0);
         chk("result", EXIT_CODE[k-16], o_RESULT);
         chk("flags", 2'h2, {o_ZERO_FLAG, o_CARRY_FLAG});
         chk("exit_fault", evict_pkg::FAULT_NONE, o_FAULT);
         chk("exit_writes", 0, n_w);
      end
      for (int t = 0; t < 5; t++)
      begin
         delay <= 4'(t * 3);
         op(99, TYP[t], 64'h0);
         chk_ok(t < 3 ? i_OWNER_EID : 64'h0, t < 3 ? i_OWNER_EID : (t == 3 ? i_OWN_EID : 64'h0),
                1'h0);
      end
      op(99, evict_pkg::REGULAR_PAGE_TYPE, 64'h0000_0000_0000_0001);
      chk_ok(i_OWNER_EID, i_OWNER_EID, 1'h1);
      print_verdict();
   end
endmodule : tb_page_evict_leaf
